// file: bptg_defines.vh
// Purpose: constants shared by the triggered pulse generator files
// Assumes: word addressing on the register bus
// Notes:   channel registers sit at {chan[2:0], reg[1:0]}
`ifndef BPTG_DEFINES_VH
`define BPTG_DEFINES_VH

// channel count and per-channel trigger queue depth
`define BPTG_NCH          8
`define BPTG_QDEPTH       32
`define BPTG_QAW          5

// word address map
`define BPTG_ADDR_W       6
`define BPTG_REG_CTRL     2'h0
`define BPTG_REG_DELAY    2'h1
`define BPTG_REG_WIDTH    2'h2
`define BPTG_REG_STAT     2'h3
`define BPTG_ADDR_EXTSTAT 6'h20
`define BPTG_ADDR_EXTDEC  6'h21
`define BPTG_CHAN_SEL     1'h0

// control register fields
`define BPTG_FLAG_BUFF    8'h01
`define BPTG_FLAG_EIDD    8'h04
`define BPTG_FLAG_EIDA    8'h08
`define BPTG_CTRL_EN      8
`define BPTG_CTRL_RST     32'h0000_0000

// decision write and status fields
`define BPTG_DEC_VAL      16
`define BPTG_EXT_PEND     16
`define BPTG_EXT_DECD     17
`define BPTG_EXT_DVAL     18
`define BPTG_STAT_LVL     2
`define BPTG_STAT_QCNT    8
`define BPTG_STAT_FULL    16

`endif

// file: bptg_fifo.v
// Purpose: per-channel queue of pending trigger time stamps
// Assumes: push is ignored when full, pop is ignored when empty
// Notes:   read data is the head entry, valid while not empty
`timescale 1ns/1ps
`default_nettype none

module bptg_fifo #(
  parameter W     = 32,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // clock and reset
  input  wire          sys_clk_i,
  input  wire          srst_i,
  // write side
  input  wire          push_i,
  input  wire [W-1:0]  data_i,
  // read side
  input  wire          pop_i,
  output wire [W-1:0]  data_o,
  // state
  output wire          full_o,
  output wire          empty_o,
  output wire [AW:0]   count_o
);

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;

  wire do_push = push_i & ~full_o;
  wire do_pop  = pop_i & ~empty_o;

  assign full_o  = (count == DEPTH[AW:0]);
  assign empty_o = (count == {(AW+1){1'b0}});
  assign count_o = count;
  assign data_o  = mem[rd_ptr];

  always @(posedge sys_clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= data_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop & ~do_push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: bptg_top.v
// Purpose: eight triggered pulse channels with trigger queues and
//          host-decided pulses, behind an Avalon-MM slave
// Assumes: delay and width counted in sys_clk_i cycles
// Notes:   one wait state on every bus access
// Notes on behaviour
// R1 - A taken trigger starts an active period: the delay, then the width.
// R2 - Without the queue, trigger edges while active are dropped.
// R3 - With the queue, edges while active are kept and replayed in order.
// R4 - Each queue holds 32 triggers and drops edges while full.
// R5 - Queueing must not be combined with a continuous trigger mode.
// R6 - All eight channels may queue at once, each with its own queue.
// R7 - In external mode each pulse gets an index reported during its delay.
// R8 - A host decision of 1 enables the pulse and 0 suppresses it.
// R9 - The host returns the decision with the index before the delay ends.
// R10 - Without a decision by the delay end, the default decision is used.
// R11 - Flag 0x04 gives a suppress default and 0x08 an enable default.
// R12 - External mode acts only on the highest enabled channel.
// R13 - An enabled pulse drives the target high for the width, else low.
// R14 - The pulse index grows by one for every external-mode pulse.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bptg_defines.vh"

module bptg_top #(
  parameter NCH   = `BPTG_NCH,
  parameter CNT_W = 32,
  parameter IDX_W = 16
) (
  // clock and reset
  input  wire                    sys_clk_i,
  input  wire                    srst_i,
  // avalon-mm slave
  input  wire [`BPTG_ADDR_W-1:0] avs_address_i,
  input  wire                    avs_read_i,
  input  wire                    avs_write_i,
  input  wire [31:0]             avs_writedata_i,
  input  wire [3:0]              avs_byteenable_i,
  output reg  [31:0]             avs_readdata_o,
  output wire                    avs_waitrequest_o,
  // trigger sources and targets
  input  wire [NCH-1:0]          trig_i,
  output wire [NCH-1:0]          pulse_o,
  // index report towards the host
  output reg  [IDX_W-1:0]        ext_index_o,
  output reg                     ext_index_stb_o
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_WIDTH = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // register file

  reg  [31:0]          ctrl_r [0:NCH-1];
  reg  [31:0]          dly_r  [0:NCH-1];
  reg  [31:0]          wid_r  [0:NCH-1];
  reg                  ack_r;
  reg  [31:0]          rd_mux;
  wire [31:0]          be_mask;
  wire [2:0]           a_ch   = avs_address_i[4:2];
  wire [1:0]           a_reg  = avs_address_i[1:0];
  wire                 a_chan = (avs_address_i[5] == `BPTG_CHAN_SEL);
  wire                 req    = avs_read_i | avs_write_i;
  wire                 wr_do  = avs_write_i & ack_r;
  integer              k, k_sel, k_def;

  // per-channel state, gathered for status reads and the external-mode logic
  wire [2*NCH-1:0]     st_v;
  wire [NCH-1:0]       lvl_v;
  wire [NCH-1:0]       qfull_v;
  wire [6*NCH-1:0]     qcnt_v;
  wire [NCH-1:0]       start_v;
  wire [NCH-1:0]       dend_v;

  // external-input shared state and the time stamp counter
  reg  [IDX_W-1:0]     idx_next;
  reg  [IDX_W-1:0]     idx_cur;
  reg                  ext_pend;
  reg                  dec_valid;
  reg                  dec_val;
  reg  [NCH-1:0]       ext_sel;
  reg  [CNT_W-1:0]     now;

  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // the request is held until the single wait state has passed
  assign avs_waitrequest_o = req & ~ack_r;

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    if (a_chan && a_ch < NCH) begin
      case (a_reg)
        `BPTG_REG_CTRL:  rd_mux = ctrl_r[a_ch];
        `BPTG_REG_DELAY: rd_mux = dly_r[a_ch];
        `BPTG_REG_WIDTH: rd_mux = wid_r[a_ch];
        `BPTG_REG_STAT: begin
          rd_mux[1:0]                 = st_v[2*a_ch +: 2];
          rd_mux[`BPTG_STAT_LVL]      = lvl_v[a_ch];
          rd_mux[`BPTG_STAT_QCNT +: 6] = qcnt_v[6*a_ch +: 6];
          rd_mux[`BPTG_STAT_FULL]     = qfull_v[a_ch];
        end
        default: rd_mux = 32'h0000_0000;
      endcase
    end else if (avs_address_i == `BPTG_ADDR_EXTSTAT) begin
      rd_mux[IDX_W-1:0]      = idx_cur;
      rd_mux[`BPTG_EXT_PEND] = ext_pend;
      rd_mux[`BPTG_EXT_DECD] = dec_valid;
      rd_mux[`BPTG_EXT_DVAL] = dec_val;
    end
  end

  // unmapped reads return zero, unmapped writes are dropped
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_r) begin
      avs_readdata_o <= rd_mux;
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (k = 0; k < NCH; k = k + 1) begin
        ctrl_r[k] <= `BPTG_CTRL_RST;
        dly_r[k]  <= 32'h0000_0000;
        wid_r[k]  <= 32'h0000_0000;
      end
    end else if (wr_do && a_chan && a_ch < NCH) begin
      case (a_reg)
        `BPTG_REG_CTRL: begin
          ctrl_r[a_ch] <= (ctrl_r[a_ch] & ~be_mask) |
                          (avs_writedata_i & be_mask);
        end
        `BPTG_REG_DELAY: begin
          dly_r[a_ch] <= (dly_r[a_ch] & ~be_mask) |
                         (avs_writedata_i & be_mask);
        end
        `BPTG_REG_WIDTH: begin
          wid_r[a_ch] <= (wid_r[a_ch] & ~be_mask) |
                         (avs_writedata_i & be_mask);
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time base and external channel choice

  // free-running stamp; wrap is harmless as only differences are used
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      now <= {CNT_W{1'b0}};
    end else begin
      now <= now + 1'b1;
    end
  end

  // highest enabled channel wins, and is chosen only if it carries an external flag
  always @* begin
    ext_sel = {NCH{1'b0}};
    for (k_sel = 0; k_sel < NCH; k_sel = k_sel + 1) begin
      if (ctrl_r[k_sel][`BPTG_CTRL_EN]) begin
        ext_sel = {NCH{1'b0}};                                   // R12
        ext_sel[k_sel] = |(ctrl_r[k_sel][7:0] &
                       (`BPTG_FLAG_EIDD | `BPTG_FLAG_EIDA));     // R12
      end
    end
  end

  wire ext_on   = |(start_v & ext_sel);
  wire ext_end  = |(dend_v & ext_sel);
  wire dec_hit  = wr_do && (avs_address_i == `BPTG_ADDR_EXTDEC) &&
                  ext_pend &&
                  (avs_writedata_i[IDX_W-1:0] == idx_cur);        // R9
  reg  def_on;

  always @* begin
    def_on = 1'b0;
    for (k_def = 0; k_def < NCH; k_def = k_def + 1) begin
      if (ext_sel[k_def]) begin
        def_on = |(ctrl_r[k_def][7:0] & `BPTG_FLAG_EIDA);        // R11
      end
    end
  end

  // a new pulse start wins over a decision or delay end in that cycle
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      idx_next        <= {IDX_W{1'b0}};
      idx_cur         <= {IDX_W{1'b0}};
      ext_pend        <= 1'b0;
      dec_valid       <= 1'b0;
      dec_val         <= 1'b0;
      ext_index_o     <= {IDX_W{1'b0}};
      ext_index_stb_o <= 1'b0;
    end else begin
      ext_index_stb_o <= ext_on;                                 // R7
      if (ext_on) begin
        idx_cur     <= idx_next;                                 // R7
        idx_next    <= idx_next + 1'b1;                          // R14
        ext_index_o <= idx_next;                                 // R7
        ext_pend    <= 1'b1;
        dec_valid   <= 1'b0;
        dec_val     <= 1'b0;
      end else begin
        if (ext_end) begin
          ext_pend <= 1'b0;
        end
        if (dec_hit) begin
          dec_valid <= 1'b1;
          dec_val   <= avs_writedata_i[`BPTG_DEC_VAL];           // R8
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger synchronisers

  reg [NCH-1:0] trig_s1;
  reg [NCH-1:0] trig_s2;
  reg [NCH-1:0] trig_s3;

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      trig_s1 <= {NCH{1'b0}};
      trig_s2 <= {NCH{1'b0}};
      trig_s3 <= {NCH{1'b0}};
    end else begin
      trig_s1 <= trig_i;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channels

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gen_ch
      reg  [1:0]       st;
      reg  [CNT_W-1:0] cnt;
      reg              lvl;
      wire             en      = ctrl_r[g][`BPTG_CTRL_EN];
      wire             buf_en  = |(ctrl_r[g][7:0] & `BPTG_FLAG_BUFF);
      wire             edg     = trig_s2[g] & ~trig_s3[g];    // R5
      wire             busy    = (st != ST_IDLE);
      wire             q_full;
      wire             q_empty;
      wire [5:0]       q_cnt;
      wire [CNT_W-1:0] q_stamp;
      wire [CNT_W-1:0] dly     = dly_r[g][CNT_W-1:0];
      wire [CNT_W-1:0] wid     = wid_r[g][CNT_W-1:0];
      wire [CNT_W-1:0] elapsed = now - q_stamp;
      // time already spent queued is taken off the replayed delay
      wire [CNT_W-1:0] rem     = (elapsed >= dly) ? {CNT_W{1'b0}}
                                                  : dly - elapsed;  // R3
      wire             start_q = en & ~busy & ~q_empty;           // R3
      wire             start_n = en & ~busy & q_empty & edg;      // R1
      // an edge is queued only when it cannot start a pulse now
      wire             q_push  = en & buf_en & edg &
                                 (busy | ~q_empty);               // R3
      wire             dly_end = (st == ST_DELAY) &&
                                 (cnt == {CNT_W{1'b0}});
      wire             go      = ~ext_sel[g] |
                                 (dec_valid ? dec_val : def_on);  // R10

      // one queue per channel, flushed while the channel is off
      bptg_fifo #(
        .W     (CNT_W),
        .DEPTH (`BPTG_QDEPTH),
        .AW    (`BPTG_QAW)
      ) u_queue (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i | ~en),
        .push_i    (q_push),                                      // R4
        .data_i    (now),
        .pop_i     (start_q),
        .data_o    (q_stamp),
        .full_o    (q_full),
        .empty_o   (q_empty),
        .count_o   (q_cnt)
      );                                                          // R6

      always @(posedge sys_clk_i) begin
        if (srst_i | ~en) begin
          st  <= ST_IDLE;
          cnt <= {CNT_W{1'b0}};
          lvl <= 1'b0;
        end else begin
          case (st)
            ST_IDLE: begin
              lvl <= 1'b0;
              if (start_q) begin
                st  <= ST_DELAY;
                cnt <= rem;                                       // R3
              end else if (start_n) begin
                st  <= ST_DELAY;
                cnt <= dly;                                       // R1
              end
            end
            ST_DELAY: begin
              // edges here are queued or dropped, never restart
              if (dly_end) begin
                st  <= ST_WIDTH;                                  // R2
                cnt <= (wid == {CNT_W{1'b0}}) ? wid
                                              : wid - 1'b1;
                lvl <= go;                                        // R13
              end else begin
                cnt <= cnt - 1'b1;
              end
            end
            ST_WIDTH: begin
              if (cnt == {CNT_W{1'b0}}) begin
                st  <= ST_IDLE;                                   // R2
                lvl <= 1'b0;
              end else begin
                cnt <= cnt - 1'b1;
              end
            end
            default: begin
              st  <= ST_IDLE;
              lvl <= 1'b0;
            end
          endcase
        end
      end

      assign st_v[2*g +: 2] = st;
      assign lvl_v[g]       = lvl;
      assign qfull_v[g]     = q_full;
      assign qcnt_v[6*g +: 6] = q_cnt;
      assign start_v[g]     = start_q | start_n;
      assign dend_v[g]      = dly_end;
      assign pulse_o[g]     = lvl;                                // R13
    end
  endgenerate

endmodule

`default_nettype wire

// file: bptg_props.sv
// Purpose: port checker for the triggered pulse generator
// Assumes: register writes use all four byte lanes
// Notes:   width check mirrors each channel's WIDTH writes
`timescale 1ns/1ps
`default_nettype none
module bptg_props #(
  parameter NCH   = 8,
  parameter CNT_W = 32,
  parameter IDX_W = 16
) (
  // clock and reset
  input wire logic             sys_clk_i,
  input wire logic             srst_i,
  // register bus
  input wire logic [5:0]       avs_address_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic [31:0]      avs_writedata_i,
  input wire logic [3:0]       avs_byteenable_i,
  input wire logic [31:0]      avs_readdata_o,
  input wire logic             avs_waitrequest_o,
  // targets and index report
  input wire logic [NCH-1:0]   pulse_o,
  input wire logic [IDX_W-1:0] ext_index_o,
  input wire logic             ext_index_stb_o
);
  logic             seen;
  logic [IDX_W-1:0] last;
  wire  [IDX_W-1:0] nxt_idx = last + 1'b1;
  wire              req = avs_read_i || avs_write_i;
  wire              wr_ok = avs_write_i && !avs_waitrequest_o &&
                            avs_byteenable_i == 4'hF;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      seen <= 1'b0;
      last <= '0;
    end else if (ext_index_stb_o) begin
      seen <= 1'b1;
      last <= ext_index_o;
    end
  end
  a_strobe_single: assert property (ext_index_stb_o |=>
    !ext_index_stb_o) else $error("index strobe longer than one cycle");
  a_index_first: assert property (ext_index_stb_o && !seen |->
    ext_index_o == '0) else $error("first index not zero");
  a_index_step: assert property (ext_index_stb_o && seen |->
    ext_index_o == nxt_idx) else $error("index did not step by one");
  a_wait_single: assert property (req && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("more than one wait state");
  a_wait_idle: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without a request");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i > 6'h21 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    logic [31:0] wid;
    logic [31:0] hl;
    always @(posedge sys_clk_i) begin
      if (srst_i) begin
        wid <= '0;
        hl  <= '0;
      end else begin
        if (wr_ok && avs_address_i == 6'(k * 4 + 2))
          wid <= avs_writedata_i;
        hl <= pulse_o[k] ? hl + 32'h1 : 32'h0;
      end
    end
    // a zero width still yields one high cycle
    a_width_exact: assert property ($fell(pulse_o[k]) |->
      hl == (wid == 32'h0 ? 32'h1 : wid)) else $error("wrong pulse width");
    a_low_gap: assert property ($fell(pulse_o[k]) |-> (!pulse_o[k]) [*2])
      else $error("no delay between pulses");
  end
  c_strobe: cover property (ext_index_stb_o);
  c_pulse_end: cover property ($fell(pulse_o[0]));
  c_read_done: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind bptg_top bptg_props #(.NCH(NCH), .CNT_W(CNT_W), .IDX_W(IDX_W)) u_props (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .pulse_o(pulse_o), .ext_index_o(ext_index_o),
  .ext_index_stb_o(ext_index_stb_o));
`default_nettype wire

// file: bptg_host.sv
// Purpose: host model, bus master and per-pulse decision maker
// Assumes: waitrequest is polled, no latency is assumed
// Notes:   odd indices are activated, even ones suppressed
`timescale 1ns/1ps
`default_nettype none
module bptg_host (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // avalon-mm master
  output var  logic [5:0]  avs_address_o,
  output var  logic        avs_read_o,
  output var  logic        avs_write_o,
  output var  logic [31:0] avs_writedata_o,
  output var  logic [3:0]  avs_byteenable_o,
  input  wire logic [31:0] avs_readdata_i,
  input  wire logic        avs_waitrequest_i,
  // index report and decision control
  input  wire logic [15:0] ext_index_i,
  input  wire logic        ext_index_stb_i,
  input  wire logic        quiet_i,
  output var  logic        bus_err_o
);
  logic [15:0] idx;
  logic [31:0] q;
  logic        busy;
  initial begin
    busy = 1'b0;
    avs_address_o = 6'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'hF;
    bus_err_o = 1'b0;
  end
  ////////////////////////////////////////
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    // a second caller waits its turn, and the overlap is reported
    if (busy) bus_err_o <= 1'b1;
    while (busy) @(posedge sys_clk_i);
    busy = 1'b1;
    @(posedge sys_clk_i);
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_write_o <= w;
    avs_read_o <= !w;
    // held until the edge at which waitrequest is sampled low
    @(posedge sys_clk_i);
    while (avs_waitrequest_i) @(posedge sys_clk_i);
    rd = avs_readdata_i;
    avs_write_o <= 1'b0;
    avs_read_o <= 1'b0;
    busy = 1'b0;
  endtask
  // answer at once, far inside the 0x28 delay the bench programs for external mode
  always @(negedge sys_clk_i) begin
    if (ext_index_stb_i && !quiet_i && !srst_i) begin
      idx = ext_index_i;
      bus(1'b1, 6'h21, {15'h0, idx[0], idx}, q);
    end
  end
endmodule
`default_nettype wire

// file: buffered_trigger_pulse_gen_test.sv
// Purpose: self-checking bench for the triggered pulse generator
// Assumes: the host model owns the register bus
// Notes:   pulse lengths are sampled on falling edges
`timescale 1ns/1ps
`default_nettype none
module buffered_trigger_pulse_gen_test;
  logic        sys_clk_i, srst_i, rd, wr, wreq, stb, quiet, bus_err;
  logic [5:0]  adr;
  logic [31:0] wd, rdat, q;
  logic [3:0]  be;
  logic [7:0]  trig, pls, prv;
  logic [15:0] idx, exp_idx;
  int          err_count, comparisons, np[8], n0[8], l1, l2, w1, w2;
  bptg_top u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .trig_i(trig), .pulse_o(pls),
    .ext_index_o(idx), .ext_index_stb_o(stb));
  bptg_host u_host (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr),
    .avs_writedata_o(wd), .avs_byteenable_o(be), .avs_readdata_i(rdat),
    .avs_waitrequest_i(wreq), .ext_index_i(idx), .ext_index_stb_i(stb),
    .quiet_i(quiet), .bus_err_o(bus_err));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr32(input logic [5:0] a, input logic [31:0] d);
    u_host.bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    u_host.bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic edges(input logic [7:0] m, input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk_i) trig <= m;
      repeat (2) @(posedge sys_clk_i);
      trig <= 8'h00;
      repeat (gap) @(posedge sys_clk_i);
    end
  endtask
  task automatic meas(input logic [31:0] d, output int lat, output int wid);
    wr32(6'h01, d);
    @(posedge sys_clk_i) trig <= 8'h01;
    lat = 0;
    wid = 0;
    while (!pls[0] && lat < 300) @(negedge sys_clk_i) lat++;
    while (pls[0] && wid < 300) @(negedge sys_clk_i) wid++;
    @(posedge sys_clk_i) trig <= 8'h00;
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(negedge sys_clk_i) begin
    prv <= pls;
    for (int k = 0; k < 8; k++) if (pls[k] && !prv[k]) np[k] <= np[k] + 1;
    if (stb) begin
      chk({16'h0, idx}, {16'h0, exp_idx});
      exp_idx <= exp_idx + 16'h1;
    end
  end
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    $display("Error at %0t: run timed out", $time);
    err_count++;
    results();
  end
  initial begin
    srst_i = 1'b1;
    trig = 8'h00;
    quiet = 1'b0;
    prv = 8'h00;
    exp_idx = 16'h0;
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd_chk(6'h00, 32'h0);
    rd_chk(6'h20, 32'h0);
    rd_chk(6'h3F, 32'h0);
    $display("test reset values done");
    wr32(6'h02, 32'h6);
    wr32(6'h00, 32'h100);
    meas(32'h4, l1, w1);
    meas(32'hC, l2, w2);
    chk(l2 - l1, 32'h8);
    chk(w1, 32'h6);
    chk(w2, 32'h6);
    $display("test delay and width done");
    wr32(6'h02, 32'h14);
    wr32(6'h01, 32'h4);
    n0 = np;
    edges(8'h01, 3, 2);
    repeat (40) @(posedge sys_clk_i);
    chk(np[0] - n0[0], 32'h1);
    $display("test dropped triggers done");
    for (int c = 0; c < 8; c++) begin
      wr32(6'(c * 4 + 1), 32'h2);
      wr32(6'(c * 4 + 2), 32'h190);
      wr32(6'(c * 4), 32'h101);
    end
    n0 = np;
    // one trigger starts, 40 arrive while active: 32 kept, 8 lost
    edges(8'hFF, 41, 2);
    for (int c = 0; c < 8; c++)
      rd_chk(6'(c * 4 + 3), 32'h0001_2006);
    for (int i = 0; i < 15000 && np[7] - n0[7] < 33; i++)
      @(posedge sys_clk_i);
    repeat (410) @(posedge sys_clk_i);
    for (int c = 0; c < 8; c++) chk(np[c] - n0[c], 32'h21);
    rd_chk(6'h03, 32'h0);
    $display("test trigger queue done");
    for (int c = 0; c < 8; c++) wr32(6'(c * 4), 32'h0);
    for (int c = 3; c < 6; c += 2) begin
      wr32(6'(c * 4 + 1), 32'h28);
      wr32(6'(c * 4 + 2), 32'h3);
      wr32(6'(c * 4), 32'h104);
    end
    n0 = np;
    edges(8'h28, 4, 60);
    chk(np[3] - n0[3], 32'h4);
    chk(np[5] - n0[5], 32'h2);
    chk({16'h0, exp_idx}, 32'h4);
    quiet <= 1'b1;
    n0 = np;
    edges(8'h20, 2, 60);
    chk(np[5] - n0[5], 32'h0);
    wr32(6'h14, 32'h108);
    n0 = np;
    edges(8'h20, 2, 60);
    chk(np[5] - n0[5], 32'h2);
    chk({31'h0, bus_err}, 32'h0);
    $display("test host decisions done");
    results();
  end
endmodule
`default_nettype wire
